// [cwr_watchdog.sv]
// countdown watchdog with reset pulse, APB register access
// assumes synchronous pins, one clock, option straps held steady
// Functional notes
// - the seven-bit count drops by one every 12288 cycles, giving 64 timeout steps.
// - when armed and the count goes from 40h to 3Fh a reset pulse of about 500 ns starts.
// - the unit starts disarmed unless the hardware watchdog option is set, and once armed only a reset disarms it.
// - writing the arm bit set with the top count bit clear gives a software reset.
// - the hardware watchdog option keeps the unit armed whatever the arm bit holds.
// - the wait instruction has no effect on counting or on reset generation.
// - with reset on halt selected and the unit armed, a halt resets at once.
// - otherwise halting freezes the count and blocks resets until wake up.
// - after an interrupt wake up counting resumes only after 4096 clocks.
// - reset loads the control register with 7Fh.
`timescale 1ns/100ps
`default_nettype none
`include "cwr_consts.svh"
module cwr_watchdog
  import cwr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_watchdog_opt,
  input  wire logic        reset_on_halt_opt,
  input  wire logic        wait_exec,
  input  wire logic        halt_exec,
  input  wire logic        ext_wake,
  output logic             reset_n_out
);
  // ==========================================================
  // state
  cwr_state_s s_r;
  cwr_state_s s_nxt;
  logic       armed;
  logic       acc;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       step;
  logic       counting;
  logic [6:0] cnt_next;
  logic       sw_fire;

  // bus decode, zero wait states
  // the slave never stretches a transfer, so pready is tied high;
  // an unmapped offset answers with an error and reads back zero,
  // which keeps a stray pointer from arming or firing the unit
  assign acc      = psel & penable;
  assign hit_ctrl = paddr == `CWR_CTRL_OFFSET;
  assign hit_stat = paddr == `CWR_STAT_OFFSET;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~hit_ctrl & ~hit_stat;

  // the option strap overrides the arm bit
  assign armed    = s_r.ctrl[`CWR_ARM_POS] | hw_watchdog_opt;
  // wait_exec intentionally unused: wait mode changes nothing
  assign counting = s_r.mode == CWR_RUN;
  assign step     = counting & (s_r.presc == `CWR_STEP_CYCLES - 14'h0001);
  assign sw_fire  = acc & pwrite & hit_ctrl & pstrb[0] & pwdata[`CWR_ARM_POS]
                    & ~pwdata[`CWR_TOP_POS];

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt    = s_r;
    cnt_next = s_r.ctrl[6:0] - 7'h01;
    // free running prescaler, frozen while halted and during the wake delay
    if (counting)
    begin
      s_nxt.presc = step ? 14'h0000 : s_r.presc + 14'h0001;
    end
    if (step)
    begin
      s_nxt.ctrl[6:0] = cnt_next;
      if (armed && s_r.ctrl[`CWR_TOP_POS:0] == `CWR_EXPIRE_COUNT)
      begin
        s_nxt.rst_drive = 1'b1;
      end
    end
    // software write: arm bit is set-only
    if (acc && pwrite && hit_ctrl && pstrb[0])
    begin
      s_nxt.ctrl[6:0] = pwdata[6:0];
      s_nxt.ctrl[`CWR_ARM_POS] = s_r.ctrl[`CWR_ARM_POS] | pwdata[`CWR_ARM_POS];
      if (sw_fire)
      begin
        s_nxt.rst_drive = 1'b1;
      end
    end
    // low power entry and exit
    case (s_r.mode)
      CWR_RUN:
      begin
        if (halt_exec)
        begin
          if (reset_on_halt_opt && armed)
          begin
            s_nxt.rst_drive = 1'b1;
          end
          else
          begin
            s_nxt.mode = CWR_HALTED;
          end
        end
      end
      CWR_HALTED:
      begin
        s_nxt.rst_drive = s_r.rst_drive;
        if (!s_r.rst_drive)
        begin
          s_nxt.ctrl = s_r.ctrl; // frozen while the oscillator is off
        end
        if (ext_wake)
        begin
          s_nxt.mode     = CWR_WAKE;
          s_nxt.wake_cnt = 13'h0000;
        end
      end
      CWR_WAKE:
      begin
        s_nxt.wake_cnt = s_r.wake_cnt + 13'h0001;
        if (s_r.wake_cnt == `CWR_WAKE_CYCLES - 13'h0001)
        begin
          s_nxt.mode = CWR_RUN;
        end
      end
      default:
      begin
        s_nxt.mode = CWR_RUN;
      end
    endcase
    // reset pulse length counter
    // the pulse end acts as the chip reset seen by this unit, so it
    // wins over any write or mode change made in the same cycle
    if (s_r.rst_drive)
    begin
      s_nxt.pulse_cnt = s_r.pulse_cnt + 4'h1;
      if (s_r.pulse_cnt == 4'(`CWR_PULSE_CYCLES - 1))
      begin
        s_nxt.rst_drive = 1'b0;
        s_nxt.pulse_cnt = 4'h0;
        // the pulse resets the whole chip, including this unit
        s_nxt.ctrl  = `CWR_CTRL_RESET;
        s_nxt.mode  = CWR_RUN;
        s_nxt.presc = 14'h0000;
      end
    end
    // read data, registered for the access phase
    s_nxt.prdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      if (hit_ctrl)
      begin
        s_nxt.prdata = {24'h000000, s_nxt.ctrl};
      end
      else if (hit_stat)
      begin
        s_nxt.prdata = {28'h0000000, s_r.mode == CWR_WAKE, s_r.mode == CWR_HALTED,
                        armed, s_r.rst_drive};
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '{ctrl: `CWR_CTRL_RESET, presc: 14'h0000, wake_cnt: 13'h0000,
               pulse_cnt: 4'h0, mode: CWR_RUN, rst_drive: 1'b0,
               prdata: 32'h00000000};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata      = s_r.prdata;
  assign reset_n_out = ~s_r.rst_drive;

  // ==========================================================
  // checks
  // nine of the checks step aside while a pulse is running: its last cycle
  // reloads control, mode and prescaler and would otherwise look like a violation;
  // long spans (steps, wake delay) are checked through the counters
  // themselves rather than by repetition, which keeps the tools fast

  // control register holds its load value on release of reset
  chk_reset_load: assert property (@(posedge pclk)
    $rose(presetn) |-> s_r.ctrl == `CWR_CTRL_RESET)
    else $error("control not 7Fh after reset");

  // software can set the arm bit but never clear it
  chk_arm_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.ctrl[`CWR_ARM_POS] && !s_r.rst_drive |=> s_r.ctrl[`CWR_ARM_POS])
    else $error("arm bit cleared by software");

  // a write with arm bit set is not undone by a later zero write
  chk_arm_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit_ctrl && s_r.ctrl[`CWR_ARM_POS] && !s_r.rst_drive
    |=> s_r.ctrl[`CWR_ARM_POS])
    else $error("write cleared arm bit");

  // expiry on the 40h to 3Fh step pulls the reset line
  chk_expire_fire: assert property (@(posedge pclk) disable iff (!presetn)
    step && armed && s_r.ctrl[`CWR_TOP_POS:0] == `CWR_EXPIRE_COUNT |=> !reset_n_out)
    else $error("no reset on 40h to 3Fh");

  // the strap alone is enough for expiry to fire
  chk_hw_option: assert property (@(posedge pclk) disable iff (!presetn)
    hw_watchdog_opt && step && s_r.ctrl[`CWR_TOP_POS:0] == `CWR_EXPIRE_COUNT
    |=> !reset_n_out)
    else $error("hardware option did not fire");

  // consecutive steps are never close together
  chk_step_period: assert property (@(posedge pclk) disable iff (!presetn)
    step |=> !step [*8])
    else $error("steps too close");

  // prescaler never leaves its range
  chk_presc_range: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.presc < `CWR_STEP_CYCLES)
    else $error("prescaler out of range");

  // a step without a write drops the count by one
  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    step && !(acc && pwrite && hit_ctrl && pstrb[0]) && !s_r.rst_drive
    |=> s_r.ctrl[`CWR_TOP_POS:0] == $past(s_r.ctrl[`CWR_TOP_POS:0]) - 7'h01)
    else $error("count did not step");

  // a write lands on the count in its own cycle
  chk_write_count: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit_ctrl && pstrb[0] && !s_r.rst_drive && s_r.mode != CWR_HALTED
    |=> s_r.ctrl[`CWR_TOP_POS:0] == $past(pwdata[`CWR_TOP_POS:0]))
    else $error("write did not load count");

  // zero wait state slave
  chk_ready_const: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready dropped");

  // unmapped offsets answer with an error
  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !hit_ctrl && !hit_stat |-> pslverr)
    else $error("no error on unmapped offset");

  // mapped offsets never answer with an error
  chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    acc && (hit_ctrl || hit_stat) |-> !pslverr)
    else $error("error on mapped offset");

  // wait entry leaves the run mode alone
  chk_wait_none: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_RUN && wait_exec && !halt_exec && !s_r.rst_drive
    |=> s_r.mode == CWR_RUN)
    else $error("wait changed the mode");

  // halt with the option and the unit armed resets at once
  chk_halt_fire: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_RUN && halt_exec && reset_on_halt_opt && armed |=> !reset_n_out)
    else $error("halt did not reset");

  // halt without a reset freezes the unit
  chk_halt_enter: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_RUN && halt_exec && !(reset_on_halt_opt && armed) && !s_r.rst_drive
    |=> s_r.mode == CWR_HALTED)
    else $error("halt not entered");

  // no step while halted
  chk_halt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_HALTED |-> !step)
    else $error("count moved in halt");

  // prescaler holds while halted
  chk_presc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_HALTED && !s_r.rst_drive |=> $stable(s_r.presc))
    else $error("prescaler moved in halt");

  // an interrupt starts the wake delay from zero
  chk_wake_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_HALTED && ext_wake && !s_r.rst_drive
    |=> s_r.mode == CWR_WAKE && s_r.wake_cnt == 13'h0000)
    else $error("wake delay not started");

  // the wake delay is only left at its full count
  chk_wake_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mode == CWR_WAKE && s_r.wake_cnt != `CWR_WAKE_CYCLES - 13'h0001
    && !s_r.rst_drive |=> s_r.mode == CWR_WAKE)
    else $error("wake delay too short");

  // first cycles of the wake delay stay in wake
  chk_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.mode == CWR_WAKE) |-> s_r.mode == CWR_WAKE [*8])
    else $error("wake delay left early");

  // a software reset write pulls the line
  chk_sw_reset: assert property (@(posedge pclk) disable iff (!presetn)
    sw_fire |=> !reset_n_out)
    else $error("software reset missing");

  // pulse length is fixed
  chk_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.rst_drive) |-> s_r.rst_drive [*5] ##1 !s_r.rst_drive)
    else $error("reset pulse length wrong");

  // the end of a pulse leaves the unit in its reset state
  chk_pulse_reload: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_r.rst_drive) |-> s_r.ctrl == `CWR_CTRL_RESET && s_r.mode == CWR_RUN)
    else $error("unit not reloaded after pulse");
endmodule : cwr_watchdog
`default_nettype wire

// [cwr_consts.svh]
// constants for the countdown watchdog reset block
// assumes a 10 MHz pclk and an APB slave with 32-bit data
`ifndef CWR_CONSTS_SVH
`define CWR_CONSTS_SVH
// ==========================================================
// register map
`define CWR_CTRL_OFFSET   12'h024
`define CWR_STAT_OFFSET   12'h028
`define CWR_CTRL_RESET    8'h7F
`define CWR_ARM_POS       7
`define CWR_TOP_POS       6
`define CWR_EXPIRE_COUNT  7'h40
// ==========================================================
// timing
`define CWR_STEP_CYCLES   14'h3000
`define CWR_PULSE_NS      500
`define CWR_CLK_NS        100
`define CWR_PULSE_CYCLES  (`CWR_PULSE_NS / `CWR_CLK_NS)
`define CWR_WAKE_CYCLES   13'h1000
`endif

// [cwr_pkg.sv]
// types for the countdown watchdog reset block
// assumes cwr_consts.svh is included by users of the constants
package cwr_pkg;
  typedef enum logic [1:0] {CWR_RUN, CWR_HALTED, CWR_WAKE} cwr_mode_e;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [13:0] presc;
    logic [12:0] wake_cnt;
    logic [3:0]  pulse_cnt;
    cwr_mode_e   mode;
    logic        rst_drive;
    logic [31:0] prdata;
  } cwr_state_s;
endpackage : cwr_pkg

// [test_countdown_watchdog_reset.sv]
// testbench for the countdown watchdog: apb tasks, timeout, halt and strap cases
// assumes cwr_watchdog with zero-wait apb and a 10 MHz pclk
`timescale 1ns/100ps
`default_nettype none
`include "cwr_consts.svh"
module test_countdown_watchdog_reset;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hw_opt;
  logic        roh_opt;
  logic [2:0]  ev;
  logic        reset_n_out;
  logic [31:0] q;
  logic        err;
  int          n;
  int          n_fail;
  int          check_count;
  cwr_watchdog cwr_watchdog_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_watchdog_opt(hw_opt),
    .reset_on_halt_opt(roh_opt), .wait_exec(ev[0]), .halt_exec(ev[1]),
    .ext_wake(ev[2]), .reset_n_out(reset_n_out));
  // ==========================================================
  // clock and watchdog; the whole run needs about 70000 cycles
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  // ==========================================================
  // tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // straps only change while reset is held
  task rst(input logic h, input logic r);
    @(posedge pclk);
    presetn <= 1'b0;
    hw_opt  <= h;
    roh_opt <= r;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  // one apb transfer; the leading edge keeps back to back calls apart
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task pulse(input logic [2:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 3'h0;
  endtask : pulse
  // cycles until the reset drive goes low, capped at lim
  task wait_low(input int lim);
    n = 0;
    @(negedge pclk);
    while (reset_n_out !== 1'b0 && n < lim)
    begin
      n++;
      @(negedge pclk);
    end
  endtask : wait_low
  task plen();
    n = 0;
    while (reset_n_out === 1'b0)
    begin
      n++;
      @(negedge pclk);
    end
  endtask : plen
  // ==========================================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, hw_opt, roh_opt} = 6'h00;
    {paddr, pwdata, ev, n_fail, check_count} = '0;
    rst(1'b0, 1'b0);
    apb(1'b0, `CWR_CTRL_OFFSET, 32'h0);
    chk(q, 32'h0000007F);
    apb(1'b0, `CWR_STAT_OFFSET, 32'h0);
    chk(q[1], 1'b0);
    apb(1'b0, 12'h030, 32'h0);
    chk(err, 1'b1);
    chk(q, 32'h00000000);
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h000000C1);
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h00000041);
    apb(1'b0, `CWR_CTRL_OFFSET, 32'h0);
    chk(q, 32'h000000C1);
    pulse(3'h1);
    wait_low(30000);
    chk(n >= 12270 && n <= 24590, 1'b1);
    plen();
    chk(n, `CWR_PULSE_CYCLES);
    apb(1'b0, `CWR_CTRL_OFFSET, 32'h0);
    chk(q, 32'h0000007F);
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h000000BF);
    wait_low(10);
    chk(n <= 3, 1'b1);
    plen();
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h000000C0);
    pulse(3'h2);
    wait_low(13000);
    chk(n, 13000);
    pulse(3'h4);
    wait_low(20000);
    chk(n >= 4095 && n <= 16400, 1'b1);
    plen();
    rst(1'b0, 1'b1);
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h000000FF);
    pulse(3'h2);
    wait_low(10);
    chk(n <= 3, 1'b1);
    plen();
    rst(1'b1, 1'b0);
    apb(1'b0, `CWR_STAT_OFFSET, 32'h0);
    chk(q[1], 1'b1);
    // strap alone arms: count 40h with the arm bit clear must expire
    apb(1'b1, `CWR_CTRL_OFFSET, 32'h00000040);
    wait_low(13000);
    chk(n >= 12200 && n <= 12290, 1'b1);
    plen();
    end_of_test();
  end
endmodule : test_countdown_watchdog_reset
`default_nettype wire
